// file: port_phy_pkg.sv
// constants, field layout and mode codes of the per-port phy status/control bank
// assumes a single 125 mhz core clock shared by every file that uses it
package port_phy_pkg;

	localparam int NUM_PORTS = 5;
	localparam int ABIL_W = 5;
	localparam int MODE_W = 3;

	// byte offsets in the switch register space, port 1 first
	localparam logic [7:0] STATUS_ONE_OFFSET [0:NUM_PORTS-1] =
		'{8'h1e, 8'h2e, 8'h3e, 8'h4e, 8'h5e};
	localparam logic [7:0] CTRL_TWO_OFFSET [0:NUM_PORTS-1] =
		'{8'h1f, 8'h2f, 8'h3f, 8'h4f, 8'h5f};

	// status one fields
	localparam int ST1_MDIX_BIT = 7;
	localparam int ST1_AN_DONE_BIT = 6;
	localparam int ST1_LINK_GOOD_BIT = 5;
	localparam int ST1_ABIL_LSB = 0;
	localparam logic [7:0] ST1_RESET = 8'h00;

	// partner ability bit order inside the five-bit field
	localparam int ABIL_PAUSE = 4;
	localparam int ABIL_100_FULL = 3;
	localparam int ABIL_100_HALF = 2;
	localparam int ABIL_10_FULL = 1;
	localparam int ABIL_10_HALF = 0;

	// control/status two fields
	localparam int CS2_LOOPBACK_BIT = 7;
	localparam int CS2_RESERVED_BIT = 6;
	localparam int CS2_ISOLATE_BIT = 5;
	localparam int CS2_SOFT_RESET_BIT = 4;
	localparam int CS2_FORCE_LINK_BIT = 3;
	localparam int CS2_MODE_LSB = 0;
	localparam logic [7:0] CS2_RESET = 8'h01;

	typedef enum logic [MODE_W-1:0] {
		MODE_AN_BUSY = 3'h1,
		MODE_10_HALF = 3'h2,
		MODE_100_HALF = 3'h3,
		MODE_10_FULL = 3'h5,
		MODE_100_FULL = 3'h6
	} op_mode_t;

	// management serial view: register numbers and bit positions
	localparam logic [4:0] MII_CONTROL_REG = 5'h00;
	localparam logic [4:0] MII_STATUS_REG = 5'h01;
	localparam logic [4:0] MII_PARTNER_REG = 5'h05;
	localparam int MII_CTL_RESET_BIT = 15;
	localparam int MII_CTL_LOOPBACK_BIT = 14;
	localparam int MII_CTL_ISOLATE_BIT = 10;
	localparam logic [15:0] MII_STATUS_FIXED = 16'h7809;
	localparam int MII_STS_AN_DONE_BIT = 5;
	localparam int MII_STS_LINK_BIT = 2;
	localparam logic [15:0] MII_PARTNER_FIXED = 16'h0001;
	localparam int MII_LP_PAUSE_BIT = 10;
	localparam int MII_LP_ABIL_LSB = 5;
	localparam logic [4:0] MII_FIRST_PHY_ADDR = 5'h01;

	// status hold after a phy soft reset
	localparam int CLK_PERIOD_PS = 8000;
	localparam int SOFT_RESET_HOLD_NS = 1000;
	localparam int SOFT_RESET_HOLD_CYCLES =
		(SOFT_RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int HOLD_CNT_W = 8;

	function automatic op_mode_t encode_mode(input logic speed100, input logic full_duplex);
		op_mode_t m;
		case ({speed100, full_duplex})
			2'b00: m = MODE_10_HALF;
			2'b01: m = MODE_10_FULL;
			2'b10: m = MODE_100_HALF;
			default: m = MODE_100_FULL;
		endcase
		return m;
	endfunction

endpackage

// file: port_phy_link_status.sv
// one port's status tracker: synchronises the phy indications, holds status
// at reset values after a soft reset, and derives link and operating mode
// assumes phy indications are asynchronous to CLK; soft_reset is a CLK pulse
`timescale 1ns/1ps
module port_phy_link_status (
	input wire logic clk,
	input wire logic reset,
	input wire logic soft_reset,
	input wire logic force_link,
	input wire logic phy_link_up,
	input wire logic phy_an_done,
	input wire logic phy_mdix,
	input wire logic phy_speed100,
	input wire logic phy_full_duplex,
	input wire logic [port_phy_pkg::ABIL_W-1:0] phy_partner_abil,
	output logic [7:0] status_one,
	output logic [port_phy_pkg::MODE_W-1:0] op_mode
);

	typedef enum logic [2:0] {
		ST_NEGOTIATE = 3'b001,
		ST_LINK_UP = 3'b010,
		ST_HOLD = 3'b100
	} link_state_t;

	localparam int SYNC_W = port_phy_pkg::ABIL_W + 5;

	logic [SYNC_W-1:0] meta;
	logic [SYNC_W-1:0] sync;
	link_state_t state;
	link_state_t next_state;
	logic [port_phy_pkg::HOLD_CNT_W-1:0] hold_cnt;
	logic link_s, an_s, mdix_s, speed_s, duplex_s;
	logic [port_phy_pkg::ABIL_W-1:0] abil_s;

	always_ff @(posedge clk) begin
		if (reset) begin
			meta <= '0;
			sync <= '0;
		end else begin
			meta <= {phy_partner_abil, phy_full_duplex, phy_speed100, phy_mdix,
				phy_an_done, phy_link_up};
			sync <= meta;
		end
	end

	assign link_s = sync[0];
	assign an_s = sync[1];
	assign mdix_s = sync[2];
	assign speed_s = sync[3];
	assign duplex_s = sync[4];
	assign abil_s = sync[SYNC_W-1:5];

	always_comb begin
		next_state = state;
		case (state)
			ST_HOLD: begin
				if (hold_cnt == '0)
					next_state = ST_NEGOTIATE;
			end
			ST_NEGOTIATE: begin
				if (force_link || (link_s && an_s))
					next_state = ST_LINK_UP;
			end
			ST_LINK_UP: begin
				if (!force_link && !link_s)
					next_state = ST_NEGOTIATE;
			end
			default: next_state = ST_NEGOTIATE;
		endcase
		if (soft_reset)
			next_state = ST_HOLD;
	end

	always_ff @(posedge clk) begin
		if (reset)
			state <= ST_NEGOTIATE;
		else
			state <= next_state;
	end

	always_ff @(posedge clk) begin
		if (reset)
			hold_cnt <= '0;
		else if (soft_reset)
			hold_cnt <= port_phy_pkg::HOLD_CNT_W'(port_phy_pkg::SOFT_RESET_HOLD_CYCLES - 1);
		else if (hold_cnt != '0)
			hold_cnt <= hold_cnt - 1'b1;
	end

	// status shows reset values until the hold ends
	always_ff @(posedge clk) begin
		if (reset || state == ST_HOLD || soft_reset) begin
			status_one <= port_phy_pkg::ST1_RESET;
			op_mode <= port_phy_pkg::MODE_AN_BUSY;
		end else begin
			status_one[port_phy_pkg::ST1_MDIX_BIT] <= mdix_s;
			status_one[port_phy_pkg::ST1_AN_DONE_BIT] <= an_s;
			status_one[port_phy_pkg::ST1_LINK_GOOD_BIT] <= (state == ST_LINK_UP);
			status_one[port_phy_pkg::ST1_ABIL_LSB +: port_phy_pkg::ABIL_W] <= abil_s;
			if (state == ST_LINK_UP)
				op_mode <= port_phy_pkg::encode_mode(speed_s, duplex_s);
			else
				op_mode <= port_phy_pkg::MODE_AN_BUSY;
		end
	end

endmodule

// file: port_phy_regs.sv
// per-port phy status and control register bank of a five-port switch
// byte register port from the switch register space, plus a read view for
// the management serial engine; phy indications arrive asynchronously
//
// Overview of operation
// - status bit 7 shows crossover, bit 6 negotiation done; both reset to 0
// - status bit 5 shows good link; resets to 0
// - status bits 4..0 show partner pause, 100 full/half, 10 full/half abilities
// - control/status-2 bit 7 loops the port at its phy medium layers
// - control/status-2 copies at 0x1f, 0x2f, 0x3f, 0x4f, 0x5f, each own port
// - control/status-2 bit 5 isolates the phy from mii side and cable
// - writing 1 to bit 4 soft-resets the phy; bit reads back 0
// - control/status-2 bit 3 forces the phy link up
// - bits 2..0 show operating mode; reset value is negotiation in progress
// - mode 001 negotiating, 010 10 half, 011 100 half
// - mode 101 10 full, 110 100 full; 000, 100, 111 never shown
// - status is also readable through the standard management serial registers
`timescale 1ns/1ps
module port_phy_regs #(
	parameter int NUM_PORTS = port_phy_pkg::NUM_PORTS
) (
	input wire logic CLK,
	input wire logic RESET,
	// register space access
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	output logic REG_RDATA_VALID,
	// management serial register view
	input wire logic MII_RD,
	input wire logic [4:0] MII_PHY_ADDR,
	input wire logic [4:0] MII_REG_ADDR,
	output logic [15:0] MII_RDATA,
	output logic MII_RDATA_VALID,
	// phy indications, one bit per port; partner abilities five bits per port
	input wire logic [NUM_PORTS-1:0] PHY_LINK_UP,
	input wire logic [NUM_PORTS-1:0] PHY_AN_DONE,
	input wire logic [NUM_PORTS-1:0] PHY_MDIX,
	input wire logic [NUM_PORTS-1:0] PHY_SPEED100,
	input wire logic [NUM_PORTS-1:0] PHY_FULL_DUPLEX,
	input wire logic [NUM_PORTS*port_phy_pkg::ABIL_W-1:0] PHY_PARTNER_ABIL,
	// phy controls, one bit per port
	output logic [NUM_PORTS-1:0] PHY_LOOPBACK,
	output logic [NUM_PORTS-1:0] PHY_ISOLATE,
	output logic [NUM_PORTS-1:0] PHY_FORCE_LINK,
	output logic [NUM_PORTS-1:0] PHY_SOFT_RESET
);

	logic [NUM_PORTS-1:0] loopback;
	logic [NUM_PORTS-1:0] isolate;
	logic [NUM_PORTS-1:0] force_link;
	logic [NUM_PORTS-1:0] soft_reset_pulse;
	logic [7:0] status_one [0:NUM_PORTS-1];
	logic [port_phy_pkg::MODE_W-1:0] op_mode [0:NUM_PORTS-1];
	logic [NUM_PORTS-1:0] ctrl_hit;
	logic [NUM_PORTS-1:0] status_hit;
	logic [7:0] next_rdata;
	logic [15:0] next_mii_rdata;
	logic [4:0] mii_port_index;
	logic mii_port_valid;
	int mii_port;

	// one-hot port match for a byte offset against a table of offsets
	function automatic logic [NUM_PORTS-1:0] match_port(
		input logic [7:0] addr,
		input logic is_ctrl
	);
		logic [NUM_PORTS-1:0] hit;
		hit = '0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (is_ctrl)
				hit[p] = (addr == port_phy_pkg::CTRL_TWO_OFFSET[p]);
			else
				hit[p] = (addr == port_phy_pkg::STATUS_ONE_OFFSET[p]);
		end
		return hit;
	endfunction

	// assembles the readable control/status-2 byte of one port
	function automatic logic [7:0] ctrl_two_value(
		input logic lb,
		input logic iso,
		input logic fl,
		input logic [port_phy_pkg::MODE_W-1:0] mode
	);
		logic [7:0] v;
		v = '0;
		v[port_phy_pkg::CS2_LOOPBACK_BIT] = lb;
		v[port_phy_pkg::CS2_RESERVED_BIT] = 1'b0;
		v[port_phy_pkg::CS2_ISOLATE_BIT] = iso;
		v[port_phy_pkg::CS2_SOFT_RESET_BIT] = 1'b0;
		v[port_phy_pkg::CS2_FORCE_LINK_BIT] = fl;
		v[port_phy_pkg::CS2_MODE_LSB +: port_phy_pkg::MODE_W] = mode;
		return v;
	endfunction

	assign ctrl_hit = match_port(REG_ADDR, 1'b1);
	assign status_hit = match_port(REG_ADDR, 1'b0);

	// writable control bits; status offsets take no writes
	always_ff @(posedge CLK) begin
		if (RESET) begin
			loopback <= '0;
			isolate <= '0;
			force_link <= '0;
		end else if (REG_WR) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (ctrl_hit[p]) begin
					loopback[p] <= REG_WDATA[port_phy_pkg::CS2_LOOPBACK_BIT];
					isolate[p] <= REG_WDATA[port_phy_pkg::CS2_ISOLATE_BIT];
					force_link[p] <= REG_WDATA[port_phy_pkg::CS2_FORCE_LINK_BIT];
				end
			end
		end
	end

	// soft reset bit is never stored, only pulsed
	always_ff @(posedge CLK) begin
		if (RESET) begin
			soft_reset_pulse <= '0;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++)
				soft_reset_pulse[p] <= REG_WR && ctrl_hit[p] &&
					REG_WDATA[port_phy_pkg::CS2_SOFT_RESET_BIT];
		end
	end

	// phy control outputs
	always_ff @(posedge CLK) begin
		if (RESET) begin
			PHY_LOOPBACK <= '0;
			PHY_ISOLATE <= '0;
			PHY_FORCE_LINK <= '0;
			PHY_SOFT_RESET <= '0;
		end else begin
			PHY_LOOPBACK <= loopback;
			PHY_ISOLATE <= isolate;
			PHY_FORCE_LINK <= force_link;
			PHY_SOFT_RESET <= soft_reset_pulse;
		end
	end

	for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
		port_phy_link_status u_status (
			.clk(CLK),
			.reset(RESET),
			.soft_reset(soft_reset_pulse[g]),
			.force_link(force_link[g]),
			.phy_link_up(PHY_LINK_UP[g]),
			.phy_an_done(PHY_AN_DONE[g]),
			.phy_mdix(PHY_MDIX[g]),
			.phy_speed100(PHY_SPEED100[g]),
			.phy_full_duplex(PHY_FULL_DUPLEX[g]),
			.phy_partner_abil(PHY_PARTNER_ABIL[g*port_phy_pkg::ABIL_W +: port_phy_pkg::ABIL_W]),
			.status_one(status_one[g]),
			.op_mode(op_mode[g])
		);
	end

	// register space read mux; unmapped offsets read zero
	always_comb begin
		next_rdata = 8'h00;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (status_hit[p])
				next_rdata = status_one[p];
			if (ctrl_hit[p])
				next_rdata = ctrl_two_value(loopback[p], isolate[p], force_link[p], op_mode[p]);
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			REG_RDATA <= 8'h00;
			REG_RDATA_VALID <= 1'b0;
		end else begin
			REG_RDATA_VALID <= REG_RD;
			if (REG_RD)
				REG_RDATA <= next_rdata;
		end
	end

	// management view: phy address 1..5 selects port 1..5
	assign mii_port_index = MII_PHY_ADDR - port_phy_pkg::MII_FIRST_PHY_ADDR;
	assign mii_port_valid = (MII_PHY_ADDR >= port_phy_pkg::MII_FIRST_PHY_ADDR) &&
		(mii_port_index < 5'(NUM_PORTS));
	assign mii_port = int'(mii_port_index);

	always_comb begin
		next_mii_rdata = 16'h0000;
		if (mii_port_valid) begin
			case (MII_REG_ADDR)
				port_phy_pkg::MII_CONTROL_REG: begin
					next_mii_rdata[port_phy_pkg::MII_CTL_LOOPBACK_BIT] = loopback[mii_port];
					next_mii_rdata[port_phy_pkg::MII_CTL_ISOLATE_BIT] = isolate[mii_port];
					next_mii_rdata[port_phy_pkg::MII_CTL_RESET_BIT] = 1'b0;
				end
				port_phy_pkg::MII_STATUS_REG: begin
					next_mii_rdata = port_phy_pkg::MII_STATUS_FIXED;
					next_mii_rdata[port_phy_pkg::MII_STS_AN_DONE_BIT] =
						status_one[mii_port][port_phy_pkg::ST1_AN_DONE_BIT];
					next_mii_rdata[port_phy_pkg::MII_STS_LINK_BIT] =
						status_one[mii_port][port_phy_pkg::ST1_LINK_GOOD_BIT];
				end
				port_phy_pkg::MII_PARTNER_REG: begin
					next_mii_rdata = port_phy_pkg::MII_PARTNER_FIXED;
					next_mii_rdata[port_phy_pkg::MII_LP_PAUSE_BIT] =
						status_one[mii_port][port_phy_pkg::ABIL_PAUSE];
					next_mii_rdata[port_phy_pkg::MII_LP_ABIL_LSB +: 4] =
						status_one[mii_port][port_phy_pkg::ABIL_100_FULL:port_phy_pkg::ABIL_10_HALF];
				end
				default: next_mii_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			MII_RDATA <= 16'h0000;
			MII_RDATA_VALID <= 1'b0;
		end else begin
			MII_RDATA_VALID <= MII_RD;
			if (MII_RD)
				MII_RDATA <= next_mii_rdata;
		end
	end

endmodule

// file: port_phy_regs_properties.sv
// checker for port_phy_regs: read answers and control outputs against writes
// bound to the design; sees only its ports, single CLK domain
`timescale 1ns/1ps
module port_phy_regs_properties #(
	parameter int NUM_PORTS = 5
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic REG_RDATA_VALID,
	input wire logic MII_RD,
	input wire logic MII_RDATA_VALID,
	input wire logic [NUM_PORTS-1:0] PHY_LOOPBACK,
	input wire logic [NUM_PORTS-1:0] PHY_ISOLATE,
	input wire logic [NUM_PORTS-1:0] PHY_FORCE_LINK,
	input wire logic [NUM_PORTS-1:0] PHY_SOFT_RESET
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);
	read_answer_a: assert property (REG_RD |=> REG_RDATA_VALID)
		else $error("read not answered");
	valid_cause_a: assert property (REG_RDATA_VALID |-> $past(REG_RD))
		else $error("read valid without read");
	mii_answer_a: assert property (MII_RDATA_VALID == $past(MII_RD))
		else $error("management answer timing wrong");
	rdata_hold_a: assert property ($changed(REG_RDATA) |-> REG_RDATA_VALID)
		else $error("read data moved without read");
	loop_follow_a: assert property ((REG_WR && REG_ADDR == 8'h1f) |-> ##2
		(PHY_LOOPBACK[0] == $past(REG_WDATA[7], 2))) else $error("loopback wrong");
	iso_follow_a: assert property ((REG_WR && REG_ADDR == 8'h2f) |-> ##2
		(PHY_ISOLATE[1] == $past(REG_WDATA[5], 2))) else $error("isolate wrong");
	force_follow_a: assert property ((REG_WR && REG_ADDR == 8'h5f) |-> ##2
		(PHY_FORCE_LINK[4] == $past(REG_WDATA[3], 2))) else $error("force link wrong");
	soft_pulse_a: assert property ((REG_WR && REG_ADDR == 8'h3f && REG_WDATA[4]) |->
		##2 PHY_SOFT_RESET[2] ##1 !PHY_SOFT_RESET[2]) else $error("soft reset pulse wrong");
	ctrl_cause_a: assert property (($changed(PHY_LOOPBACK) || $changed(PHY_ISOLATE) ||
		$changed(PHY_FORCE_LINK) || |PHY_SOFT_RESET) |-> $past(REG_WR, 2))
		else $error("control moved without write");
	mode_legal_a: assert property ((REG_RDATA_VALID && $past(REG_ADDR[3:0]) == 4'hf &&
		$past(REG_ADDR[7:4]) inside {[4'h1:4'h5]}) |-> (!REG_RDATA[6] && !REG_RDATA[4] &&
		REG_RDATA[2:0] inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6})) else $error("bad control read");
	cover property (REG_RD && REG_ADDR == 8'h5e);
	cover property (|PHY_SOFT_RESET);
	cover property (MII_RD);
endmodule

bind port_phy_regs port_phy_regs_properties #(.NUM_PORTS(NUM_PORTS)) chk (.CLK(CLK),
	.RESET(RESET), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RDATA_VALID(REG_RDATA_VALID),
	.MII_RD(MII_RD), .MII_RDATA_VALID(MII_RDATA_VALID), .PHY_LOOPBACK(PHY_LOOPBACK),
	.PHY_ISOLATE(PHY_ISOLATE), .PHY_FORCE_LINK(PHY_FORCE_LINK),
	.PHY_SOFT_RESET(PHY_SOFT_RESET));

// file: link_partner.sv
// cable and link partner model: link comes up some cycles after the cable
// does, and negotiation restarts whenever the phy is soft reset
`timescale 1ns/1ps
module link_partner #(
	parameter int NEG_CYCLES = 20
) (
	input wire logic CLK,
	input wire logic [4:0] cable_up,
	input wire logic [4:0] soft_reset,
	output logic [4:0] link_up,
	output logic [4:0] an_done
);
	int cnt [0:4] = '{default: 0};
	logic [4:0] up = 5'h00;
	assign link_up = up;
	assign an_done = up;
	always @(posedge CLK) begin
		for (int p = 0; p < 5; p++) begin
			if (!cable_up[p] || soft_reset[p]) begin
				cnt[p] <= 0;
				up[p] <= 1'b0;
			end else if (cnt[p] < NEG_CYCLES) begin
				cnt[p] <= cnt[p] + 1;
			end else begin
				up[p] <= 1'b1;
			end
		end
	end
endmodule

// file: tb_top.sv
// self-checking bench for port_phy_regs with the link partner on the phy side
// assumes the 125 mhz CLK and synchronous active-high RESET of the design
`timescale 1ns/1ps
module tb_top;
	logic CLK, RESET, REG_WR, REG_RD, MII_RD, REG_RDATA_VALID, MII_RDATA_VALID;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, wd;
	logic [4:0] MII_PHY_ADDR, MII_REG_ADDR, PHY_LINK_UP, PHY_AN_DONE, PHY_MDIX, cable_up;
	logic [4:0] PHY_SPEED100, PHY_FULL_DUPLEX, PHY_LOOPBACK, PHY_ISOLATE, PHY_FORCE_LINK;
	logic [4:0] PHY_SOFT_RESET, exp_lb, exp_iso, exp_fl;
	logic [24:0] PHY_PARTNER_ABIL;
	logic [15:0] MII_RDATA;
	logic [7:0] rq [$];
	logic [15:0] mq [$];
	logic [4:0] sq [$];
	int errors = 0;
	int checks = 0;
	int cyc = 0;
	port_phy_regs uut (.CLK(CLK), .RESET(RESET), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
		.REG_RDATA_VALID(REG_RDATA_VALID), .MII_RD(MII_RD), .MII_PHY_ADDR(MII_PHY_ADDR),
		.MII_REG_ADDR(MII_REG_ADDR), .MII_RDATA(MII_RDATA), .MII_RDATA_VALID(MII_RDATA_VALID),
		.PHY_LINK_UP(PHY_LINK_UP), .PHY_AN_DONE(PHY_AN_DONE), .PHY_MDIX(PHY_MDIX),
		.PHY_SPEED100(PHY_SPEED100), .PHY_FULL_DUPLEX(PHY_FULL_DUPLEX),
		.PHY_PARTNER_ABIL(PHY_PARTNER_ABIL), .PHY_LOOPBACK(PHY_LOOPBACK),
		.PHY_ISOLATE(PHY_ISOLATE), .PHY_FORCE_LINK(PHY_FORCE_LINK),
		.PHY_SOFT_RESET(PHY_SOFT_RESET));
	link_partner lp (.CLK(CLK), .cable_up(cable_up), .soft_reset(PHY_SOFT_RESET),
		.link_up(PHY_LINK_UP), .an_done(PHY_AN_DONE));
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic close_out;
		if (errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge CLK) begin
		#1;
		if (REG_RDATA_VALID === 1'b1)
			check("REG_RDATA", REG_RDATA, rq.size() ? rq.pop_front() : 8'hee);
		if (MII_RDATA_VALID === 1'b1)
			check("MII_RDATA", MII_RDATA, mq.size() ? mq.pop_front() : 16'heeee);
		if (PHY_SOFT_RESET !== 5'h00)
			check("PHY_SOFT_RESET", PHY_SOFT_RESET, sq.size() ? sq.pop_front() : 5'h00);
		cyc++;
		if (cyc == 5000) begin
			errors++;
			close_out();
		end
	end
	function automatic logic [2:0] mode_of(input int p);
		if (!(cable_up[p] | exp_fl[p]))
			return 3'h1;
		case ({PHY_SPEED100[p], PHY_FULL_DUPLEX[p]})
			2'b00: return 3'h2;
			2'b01: return 3'h5;
			2'b10: return 3'h3;
			default: return 3'h6;
		endcase
	endfunction
	function automatic logic [7:0] cs_val(input int p);
		return {exp_lb[p], 1'b0, exp_iso[p], 1'b0, exp_fl[p], mode_of(p)};
	endfunction
	// strobe tasks leave their strobe up so that calls of one kind run back to back
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		rq.push_back(e);
		@(posedge CLK);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLK);
	endtask
	task automatic mii(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] e);
		MII_RD <= 1'b1;
		MII_PHY_ADDR <= pa;
		MII_REG_ADDR <= ra;
		mq.push_back(e);
		@(posedge CLK);
	endtask
	task automatic idle;
		REG_RD <= 1'b0;
		REG_WR <= 1'b0;
		MII_RD <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic check_port(input int p);
		logic [4:0] ab;
		logic [7:0] base;
		logic lk;
		ab = PHY_PARTNER_ABIL[5*p +: 5];
		base = 8'h1e + 8'(16 * p);
		lk = cable_up[p] | exp_fl[p];
		rd(base, {PHY_MDIX[p], cable_up[p], lk, ab});
		rd(base + 8'h01, cs_val(p));
		idle();
		mii(5'(p + 1), 5'h01, 16'h7809 | {10'h0, cable_up[p], 2'b0, lk, 2'b0});
		mii(5'(p + 1), 5'h05, {5'h0, ab[4], 1'b0, ab[3:0], 5'h01});
		mii(5'(p + 1), 5'h00, {1'b0, exp_lb[p], 3'h0, exp_iso[p], 10'h0});
		idle();
	endtask
	initial begin
		RESET = 1'b1;
		{REG_WR, REG_RD, MII_RD, REG_ADDR, REG_WDATA, MII_PHY_ADDR, MII_REG_ADDR} = '0;
		{PHY_MDIX, cable_up, PHY_SPEED100, PHY_FULL_DUPLEX, PHY_PARTNER_ABIL} = '0;
		{exp_lb, exp_iso, exp_fl} = '0;
		void'($urandom(32'h6a516fda));
		repeat (3) @(posedge CLK);
		RESET <= 1'b0;
		for (int p = 0; p < 5; p++) check_port(p);
		rd(8'h60, 8'h00);
		idle();
		mii(5'h00, 5'h01, 16'h0000);
		mii(5'h01, 5'h02, 16'h0000);
		idle();
		PHY_MDIX <= 5'($urandom);
		PHY_PARTNER_ABIL <= 25'($urandom);
		PHY_SPEED100 <= 5'b01100;
		PHY_FULL_DUPLEX <= 5'b01010;
		cable_up <= 5'h1f;
		repeat (40) @(posedge CLK);
		for (int p = 0; p < 5; p++) check_port(p);
		for (int p = 0; p < 5; p++) begin
			wd = 8'($urandom) & 8'hef;
			wr(8'h1f + 8'(16 * p), wd);
			{exp_lb[p], exp_iso[p], exp_fl[p]} = {wd[7], wd[5], wd[3]};
		end
		wr(8'h5e, 8'hff);
		idle();
		repeat (2) @(posedge CLK);
		#1;
		check("PHY_LOOPBACK", PHY_LOOPBACK, exp_lb);
		check("PHY_ISOLATE", PHY_ISOLATE, exp_iso);
		check("PHY_FORCE_LINK", PHY_FORCE_LINK, exp_fl);
		check("PHY_SOFT_RESET", PHY_SOFT_RESET, 5'h00);
		for (int p = 0; p < 5; p++) check_port(p);
		wd = 8'($urandom) | 8'h10;
		wr(8'h3f, wd);
		sq.push_back(5'h04);
		{exp_lb[2], exp_iso[2], exp_fl[2]} = {wd[7], wd[5], wd[3]};
		idle();
		rd(8'h3e, 8'h00);
		rd(8'h3f, {wd[7], 1'b0, wd[5], 1'b0, wd[3], 3'h1});
		idle();
		repeat (170) @(posedge CLK);
		check_port(2);
		exp_fl[1] = 1'b1;
		wr(8'h2f, cs_val(1));
		cable_up[1] <= 1'b0;
		PHY_MDIX[1] <= 1'b0;
		PHY_PARTNER_ABIL[9:5] <= 5'h00;
		idle();
		repeat (20) @(posedge CLK);
		check_port(1);
		exp_fl[1] = 1'b0;
		wr(8'h2f, cs_val(1));
		idle();
		repeat (20) @(posedge CLK);
		check_port(1);
		RESET <= 1'b1;
		repeat (3) @(posedge CLK);
		RESET <= 1'b0;
		{exp_lb, exp_iso, exp_fl} = '0;
		rd(8'h1f, 8'h01);
		idle();
		#1;
		check("PHY_CONTROLS", PHY_LOOPBACK | PHY_ISOLATE | PHY_FORCE_LINK, 5'h00);
		repeat (2) @(posedge CLK);
		check("pending", 16'(rq.size() + mq.size() + sq.size()), 16'h0000);
		close_out();
	end
endmodule
